// [verif/qpbmr_repeater_model.sv]
// Repeater model on the link side: select lines, port A/B transmit, port A/B capture.
// Assumes receive pins change just after the link clock rising edge.
`timescale 1ns/1ps
module qpbmr_repeater_model
  import qpbmr_pkg::*;
(
  input wire logic lclk,
  input wire logic [NIB_W-1:0] a_rx_data,
  input wire logic a_rx_valid,
  input wire logic b_rx_data,
  input wire logic b_rx_oe,
  input wire logic b_clk,
  output logic b_tx_data,
  output logic [6*CH_N-1:0] sel,
  output logic [NIB_W-1:0] a_tx_data,
  output logic a_tx_error
);
  logic [NIB_W-1:0] qa[$];
  logic [NIB_W-1:0] qb[$];
  logic [NIB_W-1:0] bw;
  int bn;
  initial begin
    sel = '0;
    a_tx_data = 4'h0;
    a_tx_error = 1'b0;
    b_tx_data = 1'b0;
    bn = 0;
  end
  always @(posedge lclk) begin
    if (a_rx_valid === 1'b1) begin
      qa.push_back(a_rx_data);
    end
    if (b_rx_oe === 1'b1) begin
      // Second half of each two-cycle bit, away from its edges
      if (bn[0]) begin
        bw[bn/2] = b_rx_data;
      end
      bn = bn + 1;
      if (bn == 8) begin
        qb.push_back(bw);
        bn = 0;
      end
    end else begin
      bn = 0;
    end
  end
  task automatic pick(input logic [6*CH_N-1:0] v);
    @(posedge lclk);
    #1 sel = v;
  endtask : pick
  task automatic send_a(input logic [NIB_W-1:0] n, input logic [6*CH_N-1:0] v, input int len);
    @(posedge lclk);
    #1 sel = v;
    a_tx_data = n;
    repeat (len) @(posedge lclk);
    #1 sel = '0;
    // Released bus shows inverted data, so a stale nibble cannot pass
    a_tx_data = ~n;
  endtask : send_a
  // serial nibble into port B, LSB first
  task automatic send_b(input logic [NIB_W-1:0] n, input logic [6*CH_N-1:0] v);
    int k;
    @(posedge lclk);
    #1;
    // Start with the slow clock low so its next rise takes bit 0
    if (b_clk) begin
      @(posedge lclk);
      #1;
    end
    sel = v;
    for (k = 0; k < NIB_W; k++) begin
      b_tx_data = n[k];
      repeat (2) @(posedge lclk);
      #1;
    end
    sel = '0;
    b_tx_data = ~n[NIB_W-1];
  endtask : send_b
endmodule : qpbmr_repeater_model

// [verif/test_quad_phy_bused_mii_router.sv]
// Self-checking bench: channel side driven here, repeater model on the link side.
// Assumes the router top with its default four channels.
`timescale 1ns/1ps
module test_quad_phy_bused_mii_router;
  import qpbmr_pkg::*;
  typedef struct packed {
    logic [1:0] m;
    logic [3:0] f, c, k, ncar, ncol, scar, fcar, shc, fcol, scol;
    logic shk;
  } qpbmr_row_t;
  logic clock, lclk, nrst, m_bus, m_smart, tx_seen, shk, a_v, a_e, a_oe, b_d, b_oe, a_te;
  logic b_t, b_clk, b_rclk, b_rc0, last_ae;
  logic [3:0] fast, carr, coll, rxv, rxe, ntxe, ntxer, rdy, txv, txer, nv, ner, ncar, ncol;
  logic [3:0] scar, fcar, scol, fcol, shc, a_d, a_t, tx_v;
  logic [15:0] rxd, ntxd, txd, nd, tx_n;
  logic [23:0] sel;
  int err_total, checked, i;
  qpbmr_row_t rows[5];

  qpbmr_router dut (
    .clock(clock), .nrst(nrst), .fast_bus_transmit_clock(lclk), .mode_bused_pin(m_bus),
    .mode_smart_pin(m_smart), .ch_fast(fast), .ch_carrier(carr), .ch_collision(coll), .ch_rx_valid(rxv),
    .ch_rx_data(rxd), .ch_rx_error(rxe), .ch_rx_ready(rdy), .ch_tx_valid(txv), .ch_tx_data(txd),
    .ch_tx_error(txer), .norm_rx_valid(nv), .norm_rx_data(nd), .norm_rx_error(ner), .norm_carrier(ncar),
    .norm_collision(ncol), .norm_tx_enable(ntxe), .norm_tx_data(ntxd), .norm_tx_error(ntxer),
    .slow_carrier_out(scar), .fast_carrier_out(fcar), .slow_collision_out(scol), .fast_collision_out(fcol),
    .shared_carrier_out(shc), .shared_collision_out(shk), .slow_receive_select(sel[3:0]),
    .fast_receive_select(sel[7:4]), .slow_transmit_select(sel[11:8]), .fast_transmit_select(sel[15:12]),
    .shared_receive_select(sel[19:16]), .shared_transmit_select(sel[23:20]), .port_a_rx_data(a_d),
    .port_a_rx_valid(a_v), .port_a_rx_error(a_e), .port_a_rx_oe(a_oe), .port_a_tx_data(a_t),
    .port_a_tx_error(a_te), .port_b_rx_data(b_d), .port_b_rx_oe(b_oe), .port_b_tx_data(b_t),
    .slow_bus_receive_clock(b_rclk), .slow_bus_transmit_clock(b_clk)
  );

  qpbmr_repeater_model rep (
    .lclk(lclk), .a_rx_data(a_d), .a_rx_valid(a_v), .b_rx_data(b_d), .b_rx_oe(b_oe), .b_clk(b_clk),
    .b_tx_data(b_t), .sel(sel), .a_tx_data(a_t), .a_tx_error(a_te)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Link clock free-running, offset by 3 ns; its edges still meet a core clock rise every 80 ns
  initial begin
    lclk = 1'b0;
    #3;
    forever #16 lclk = ~lclk;
  end
  always @(posedge clock) begin
    if (txv !== 4'h0 && tx_seen === 1'b0) begin
      tx_seen = 1'b1;
      tx_v = txv;
      tx_n = txd;
    end
  end
  always @(posedge lclk) begin
    if (a_v === 1'b1) begin
      last_ae = a_e;
    end
  end

  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic hang(input string what);
    err_total++;
    $display("Error at %0t: timeout waiting for %s", $time, what);
    test_done();
  endtask : hang
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_w
  task automatic set_mode(input logic [1:0] m, input logic [3:0] f);
    m_bus = m[1];
    m_smart = m[0];
    fast = f;
    repeat (6) @(negedge clock);
  endtask : set_mode
  // Valid stays up between words; caller lowers it after the last one
  task automatic push(input int c, input logic [3:0] n);
    int j;
    rxv[c] = 1'b1;
    rxd[4*c +: 4] = n;
    for (j = 0; j < 2000 && rdy[c] !== 1'b1; j++) begin
      @(negedge clock);
    end
    if (j == 2000) hang("channel ready");
    @(negedge clock);
  endtask : push
  task automatic wait_q(input int n, input bit on_b);
    int j;
    for (j = 0; j < 2000 && (on_b ? rep.qb.size() : rep.qa.size()) < n; j++) begin
      @(negedge clock);
    end
    if (j == 2000) hang("shared port word");
  endtask : wait_q

  initial begin
    nrst = 1'b0;
    {m_bus, m_smart, fast, carr, coll, rxv, rxe, ntxe, ntxer, tx_seen} = '0;
    {rxd, ntxd} = '0;
    err_total = 0;
    checked = 0;
    rows[0] = {2'b00, 4'h5, 4'hC, 4'h3, 4'hC, 4'h3, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0};
    rows[1] = {2'b10, 4'h5, 4'hF, 4'h6, 4'h0, 4'h0, 4'hA, 4'h5, 4'h0, 4'h4, 4'h2, 1'b0};
    rows[2] = {2'b10, 4'hA, 4'h3, 4'h9, 4'h0, 4'h0, 4'h1, 4'h2, 4'h0, 4'h8, 4'h1, 1'b0};
    rows[3] = {2'b11, 4'h5, 4'h6, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h6, 4'h0, 4'h0, 1'b0};
    rows[4] = {2'b11, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1};
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    for (i = 0; i < 5; i++) begin
      carr = rows[i].c;
      coll = rows[i].k;
      set_mode(rows[i].m, rows[i].f);
      chk(ncar, rows[i].ncar, "normal carrier");
      chk(ncol, rows[i].ncol, "normal collision");
      chk(scar, rows[i].scar, "slow carrier");
      chk(fcar, rows[i].fcar, "fast carrier");
      chk(fcol, rows[i].fcol, "fast collision");
      chk(scol, rows[i].scol, "slow collision");
      chk(shc, rows[i].shc, "shared carrier");
      chk({3'h0, shk}, {3'h0, rows[i].shk}, "shared collision");
    end
    $display("Test status rows done");
    rxv = 4'h5;
    rxe = 4'h2;
    rxd = 16'hA5C3;
    ntxe = 4'h6;
    ntxer = 4'h9;
    ntxd = 16'h1234;
    set_mode(2'b00, 4'h0);
    chk(nv, 4'h5, "normal rx valid");
    chk(ner, 4'h2, "normal rx error");
    chk_w(nd, 16'hA5C3, "normal rx data");
    chk(rdy, 4'hF, "normal ready");
    chk(txv, 4'h6, "normal tx enable");
    chk(txer, 4'h9, "normal tx error");
    chk_w(txd, 16'h1234, "normal tx data");
    {rxv, rxe, ntxe, ntxer} = '0;
    $display("Test normal ports done");
    set_mode(2'b10, 4'h5);
    tx_seen = 1'b0;
    rxv[0] = 1'b1;
    repeat (4) @(negedge clock);
    chk(rdy, 4'h0, "ready while unselected");
    chk({3'h0, a_oe}, 4'h0, "port A released");
    rep.pick(24'h000010);
    @(negedge clock);
    push(0, 4'h3);
    push(0, 4'hC);
    push(0, 4'h9);
    rxv[0] = 1'b0;
    wait_q(3, 1'b0);
    chk(rep.qa[0], 4'h3, "port A word 0");
    chk(rep.qa[1], 4'hC, "port A word 1");
    chk(rep.qa[2], 4'h9, "port A word 2");
    chk({3'h0, last_ae}, 4'h0, "port A error clear");
    $display("Test fast receive done");
    rep.pick(24'h000002);
    @(negedge clock);
    push(1, 4'h9);
    rxv[1] = 1'b0;
    wait_q(1, 1'b1);
    chk(rep.qb[0], 4'h9, "port B word");
    chk(rep.qa.size(), 4'h3, "no slow word on port A");
    $display("Test slow receive done");
    rep.send_a(4'hB, 24'h004000, 4);
    repeat (20) @(negedge clock);
    chk({3'h0, tx_seen}, 4'h1, "transmit seen");
    chk(tx_v, 4'h4, "transmit lane");
    chk(tx_n[11:8], 4'hB, "transmit nibble");
    $display("Test fast transmit done");
    tx_seen = 1'b0;
    rep.send_b(4'h6, 24'h000200);
    repeat (20) @(negedge clock);
    chk(tx_v, 4'h2, "serial transmit lane");
    chk(tx_n[7:4], 4'h6, "serial transmit nibble");
    @(posedge lclk);
    #1 b_rc0 = b_rclk;
    @(posedge lclk);
    #1 chk({3'h0, b_rclk}, {3'h0, ~b_rc0}, "slow receive clock");
    @(negedge clock);
    $display("Test slow transmit done");
    set_mode(2'b11, 4'h1);
    rep.pick(24'h010000);
    @(negedge clock);
    rxe[0] = 1'b1;
    push(0, 4'h6);
    rxv[0] = 1'b0;
    rxe[0] = 1'b0;
    wait_q(4, 1'b0);
    chk(rep.qa[3], 4'h6, "smart port A word");
    chk({3'h0, last_ae}, 4'h1, "smart port A error");
    tx_seen = 1'b0;
    rep.send_b(4'h5, 24'h200000);
    repeat (20) @(negedge clock);
    chk(tx_v, 4'h2, "smart serial lane");
    chk(tx_n[7:4], 4'h5, "smart serial nibble");
    $display("Test smart mode done");
    carr = 4'hF;
    set_mode(2'b00, 4'h0);
    nrst = 1'b0;
    repeat (12) @(negedge clock);
    chk(ncar, 4'h0, "carrier in reset");
    chk(rdy, 4'hF, "ready in reset");
    nrst = 1'b1;
    repeat (6) @(negedge clock);
    chk(ncar, 4'hF, "carrier after reset");
    $display("Test mid-run reset done");
    test_done();
  end
endmodule : test_quad_phy_bused_mii_router

// [verilog/qpbmr_buf.sv]
// Small FIFO with valid/ready on both sides.
// Assumes fill and drain share one clock; depth a power of two.
`timescale 1ns/1ps
module qpbmr_buf
  import qpbmr_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clock,
  input wire logic nrst,
  qpbmr_stream_if.snk fill,
  qpbmr_stream_if.src drain
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("qpbmr_buf depth must be a power of two, at least two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] wr_d;
  logic [PW-1:0] rd_q;
  logic [PW-1:0] rd_d;
  logic [PW:0] cnt_q;
  logic [PW:0] cnt_d;
  logic push;
  logic pop;

  assign fill.ready = (cnt_q != (PW+1)'(DEPTH));
  assign drain.valid = (cnt_q != '0);
  assign drain.data = mem_q[rd_q];

  always_comb begin
    push = fill.valid && fill.ready;
    pop = drain.valid && drain.ready;
    wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; empty count hides it
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= fill.data;
    end
  end
endmodule : qpbmr_buf

// [verilog/qpbmr_pkg.sv]
// Shared constants and types for the quad channel bused MII router.
// Assumes nibble-wide channel cores and a 2-entry receive buffer.
package qpbmr_pkg;
  localparam int CH_N = 4;
  localparam int NIB_W = 4;
  localparam int WORD_W = 6;
  localparam int WORD_ERR = 4;
  localparam int WORD_FAST = 5;
  localparam int BUF_DEPTH = 2;
  localparam int SLOW_BITS = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;
  typedef enum logic [1:0] {QPBMR_L_IDLE, QPBMR_L_FAST, QPBMR_L_SLOW} qpbmr_lrx_state_t;
endpackage : qpbmr_pkg

// [verilog/qpbmr_router.sv]
// Quad channel router: per-channel MII ports or speed-routed shared repeater ports.
// Assumes channel cores on clock and repeater pins timed to the fast bus clock.
//
// Operation
// - Fast channel traffic uses shared nibble port A
// - Slow channel traffic uses shared serial port B
// - Channel speed alone picks the port
// - Normal mode: four independent channel ports
// - Separate submode: per-speed per-channel select lines
// - Separate submode keeps slow and fast data apart, fast on port A, slow on port B
// - Smart submode: one speed-independent line set
// - Smart submode keeps the same speed routing
`timescale 1ns/1ps
module qpbmr_router
  import qpbmr_pkg::*;
#(
  parameter int CHANNELS = CH_N
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic fast_bus_transmit_clock,
  input wire logic mode_bused_pin,
  input wire logic mode_smart_pin,
  input wire logic [CHANNELS-1:0] ch_fast,
  input wire logic [CHANNELS-1:0] ch_carrier,
  input wire logic [CHANNELS-1:0] ch_collision,
  input wire logic [CHANNELS-1:0] ch_rx_valid,
  input wire logic [CHANNELS*NIB_W-1:0] ch_rx_data,
  input wire logic [CHANNELS-1:0] ch_rx_error,
  output logic [CHANNELS-1:0] ch_rx_ready,
  output logic [CHANNELS-1:0] ch_tx_valid,
  output logic [CHANNELS*NIB_W-1:0] ch_tx_data,
  output logic [CHANNELS-1:0] ch_tx_error,
  output logic [CHANNELS-1:0] norm_rx_valid,
  output logic [CHANNELS*NIB_W-1:0] norm_rx_data,
  output logic [CHANNELS-1:0] norm_rx_error,
  output logic [CHANNELS-1:0] norm_carrier,
  output logic [CHANNELS-1:0] norm_collision,
  input wire logic [CHANNELS-1:0] norm_tx_enable,
  input wire logic [CHANNELS*NIB_W-1:0] norm_tx_data,
  input wire logic [CHANNELS-1:0] norm_tx_error,
  output logic [CHANNELS-1:0] slow_carrier_out,
  output logic [CHANNELS-1:0] fast_carrier_out,
  output logic [CHANNELS-1:0] slow_collision_out,
  output logic [CHANNELS-1:0] fast_collision_out,
  output logic [CHANNELS-1:0] shared_carrier_out,
  output logic shared_collision_out,
  input wire logic [CHANNELS-1:0] slow_receive_select,
  input wire logic [CHANNELS-1:0] fast_receive_select,
  input wire logic [CHANNELS-1:0] slow_transmit_select,
  input wire logic [CHANNELS-1:0] fast_transmit_select,
  input wire logic [CHANNELS-1:0] shared_receive_select,
  input wire logic [CHANNELS-1:0] shared_transmit_select,
  output logic [NIB_W-1:0] port_a_rx_data,
  output logic port_a_rx_valid,
  output logic port_a_rx_error,
  output logic port_a_rx_oe,
  input wire logic [NIB_W-1:0] port_a_tx_data,
  input wire logic port_a_tx_error,
  output logic port_b_rx_data,
  output logic port_b_rx_oe,
  input wire logic port_b_tx_data,
  output logic slow_bus_receive_clock,
  output logic slow_bus_transmit_clock
);
  localparam int CN = CHANNELS;
  localparam int DW = CN * NIB_W;
  localparam int PICK_W = $clog2(CN);
  localparam int SYNC_W = 8 * CN + DW + 2;
  if (CN < 2 || CN > 8) begin : g_chan_check
    $error("qpbmr_router supports two to eight channels");
  end

  // Pin synchroniser into the core domain
  logic [SYNC_W-1:0] pin_s1_q;
  logic [SYNC_W-1:0] pin_s2_q;
  logic bused;
  logic smart;
  logic [CN-1:0] s_slow_rx, s_fast_rx, s_slow_tx, s_fast_tx, s_sh_rx, s_sh_tx, s_ntx_en, s_ntx_err;
  logic [DW-1:0] s_ntx_data;
  assign {s_sh_tx, s_sh_rx, s_fast_tx, s_slow_tx, s_fast_rx, s_slow_rx, s_ntx_err, s_ntx_en, s_ntx_data,
          smart, bused} = pin_s2_q;

  // Core domain state
  logic [CN-1:0] rx_sel, tx_sel;
  logic rx_any;
  logic [PICK_W-1:0] rx_pick;
  logic hs_busy_q, hs_busy_d, hs_req_q, hs_req_d;
  logic [WORD_W-1:0] hs_data_q, hs_data_d;
  logic [SYNC_STAGES-1:0] ack_s_q;
  logic [2:0] txa_s_q, txb_s_q;
  logic txa_ev, txb_ev;
  logic [CN-1:0] nrx_v_q, nrx_v_d, nrx_e_q, nrx_e_d, ncrs_q, ncrs_d, ncol_q, ncol_d;
  logic [DW-1:0] nrx_data_q, nrx_data_d, tx_data_q, tx_data_d;
  logic [CN-1:0] tx_v_q, tx_v_d, tx_e_q, tx_e_d;
  logic [CN-1:0] scrs_q, scrs_d, fcrs_q, fcrs_d, scol_q, scol_d, fcol_q, fcol_d, shcrs_q, shcrs_d;
  logic shcol_q, shcol_d;

  // Link domain state
  logic [1:0] lrst_q;
  logic lrst_n;
  logic [SYNC_STAGES-1:0] req_s_q;
  logic ack_l_q, ack_l_d, slow_clk_q;
  qpbmr_lrx_state_t lst_q, lst_d;
  logic [WORD_W-1:0] word_q, word_d;
  logic [1:0] bit_q, bit_d, sb_cnt_q, sb_cnt_d;
  logic [NIB_W-1:0] a_data_q, a_data_d, sb_q, sb_d, txb_hold_q, txb_hold_d;
  logic a_valid_q, a_valid_d, a_err_q, a_err_d, b_data_q, b_data_d, b_oe_q, b_oe_d;
  logic txa_tog_q, txa_tog_d, txb_tog_q, txb_tog_d, fast_tx_on, slow_tx_on;
  logic [NIB_W:0] txa_hold_q, txa_hold_d;

  qpbmr_stream_if #(.WIDTH(WORD_W)) fill_if ();
  qpbmr_stream_if #(.WIDTH(WORD_W)) drain_if ();

  always_comb begin
    rx_any = 1'b0;
    rx_pick = '0;
    for (int c = CN - 1; c >= 0; c--) begin
      rx_sel[c] = smart ? s_sh_rx[c] : (ch_fast[c] ? s_fast_rx[c] : s_slow_rx[c]);
      tx_sel[c] = smart ? s_sh_tx[c] : (ch_fast[c] ? s_fast_tx[c] : s_slow_tx[c]);
      if (rx_sel[c] && ch_rx_valid[c]) begin
        rx_any = 1'b1;
        rx_pick = PICK_W'(c);
      end
    end
  end

  // word carries the channel's own speed
  assign fill_if.valid = bused && rx_any;
  assign fill_if.data = {ch_fast[rx_pick], ch_rx_error[rx_pick], ch_rx_data[rx_pick*NIB_W +: NIB_W]};
  for (genvar g = 0; g < CN; g++) begin : g_ready
    assign ch_rx_ready[g] = bused ? (rx_any && rx_pick == PICK_W'(g) && fill_if.ready) : 1'b1;
  end

  qpbmr_buf #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clock(clock),
    .nrst(nrst),
    .fill(fill_if),
    .drain(drain_if)
  );

  assign drain_if.ready = !hs_busy_q;

  always_comb begin
    hs_busy_d = hs_busy_q;
    hs_req_d = hs_req_q;
    hs_data_d = hs_data_q;
    if (hs_busy_q && ack_s_q[1] == hs_req_q) begin
      hs_busy_d = 1'b0;
    end
    if (drain_if.valid && !hs_busy_q) begin
      hs_busy_d = 1'b1;
      hs_req_d = ~hs_req_q;
      hs_data_d = drain_if.data;
    end
    // normal mode passes each channel straight
    nrx_v_d = bused ? '0 : ch_rx_valid;
    nrx_e_d = bused ? '0 : ch_rx_error;
    nrx_data_d = ch_rx_data;
    ncrs_d = bused ? '0 : ch_carrier;
    ncol_d = bused ? '0 : ch_collision;
    // separate submode splits status per speed
    scrs_d = (bused && !smart) ? (ch_carrier & ~ch_fast) : '0;
    fcrs_d = (bused && !smart) ? (ch_carrier & ch_fast) : '0;
    scol_d = (bused && !smart) ? (ch_collision & ~ch_fast) : '0;
    fcol_d = (bused && !smart) ? (ch_collision & ch_fast) : '0;
    // smart submode uses shared status lines
    shcrs_d = (bused && smart) ? ch_carrier : '0;
    shcol_d = bused && smart && (|ch_collision);
    txa_ev = txa_s_q[2] ^ txa_s_q[1];
    txb_ev = txb_s_q[2] ^ txb_s_q[1];
    for (int c = 0; c < CN; c++) begin
      if (!bused) begin
        tx_v_d[c] = s_ntx_en[c];
        tx_e_d[c] = s_ntx_err[c];
        tx_data_d[c*NIB_W +: NIB_W] = s_ntx_data[c*NIB_W +: NIB_W];
      end else if (ch_fast[c]) begin
        // fast channels take port A words
        tx_v_d[c] = txa_ev && tx_sel[c];
        tx_e_d[c] = txa_hold_q[NIB_W];
        tx_data_d[c*NIB_W +: NIB_W] = txa_hold_q[NIB_W-1:0];
      end else begin
        // slow channels take port B words
        tx_v_d[c] = txb_ev && tx_sel[c];
        tx_e_d[c] = 1'b0;
        tx_data_d[c*NIB_W +: NIB_W] = txb_hold_q;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      ack_s_q <= '0;
      txa_s_q <= '0;
      txb_s_q <= '0;
      hs_busy_q <= 1'b0;
      hs_req_q <= 1'b0;
      hs_data_q <= '0;
      {nrx_v_q, nrx_e_q, ncrs_q, ncol_q, tx_v_q, tx_e_q} <= '0;
      {scrs_q, fcrs_q, scol_q, fcol_q, shcrs_q, shcol_q} <= '0;
      nrx_data_q <= '0;
      tx_data_q <= '0;
    end else begin
      pin_s1_q <= {shared_transmit_select, shared_receive_select, fast_transmit_select, slow_transmit_select,
                   fast_receive_select, slow_receive_select, norm_tx_error, norm_tx_enable, norm_tx_data,
                   mode_smart_pin, mode_bused_pin};
      pin_s2_q <= pin_s1_q;
      ack_s_q <= {ack_s_q[0], ack_l_q};
      txa_s_q <= {txa_s_q[1:0], txa_tog_q};
      txb_s_q <= {txb_s_q[1:0], txb_tog_q};
      hs_busy_q <= hs_busy_d;
      hs_req_q <= hs_req_d;
      hs_data_q <= hs_data_d;
      {nrx_v_q, nrx_e_q, ncrs_q, ncol_q, tx_v_q, tx_e_q} <= {nrx_v_d, nrx_e_d, ncrs_d, ncol_d, tx_v_d, tx_e_d};
      {scrs_q, fcrs_q, scol_q, fcol_q, shcrs_q, shcol_q} <= {scrs_d, fcrs_d, scol_d, fcol_d, shcrs_d, shcol_d};
      nrx_data_q <= nrx_data_d;
      tx_data_q <= tx_data_d;
    end
  end

  assign norm_rx_valid = nrx_v_q;
  assign norm_rx_error = nrx_e_q;
  assign norm_rx_data = nrx_data_q;
  assign norm_carrier = ncrs_q;
  assign norm_collision = ncol_q;
  assign ch_tx_valid = tx_v_q;
  assign ch_tx_error = tx_e_q;
  assign ch_tx_data = tx_data_q;
  assign slow_carrier_out = scrs_q;
  assign fast_carrier_out = fcrs_q;
  assign slow_collision_out = scol_q;
  assign fast_collision_out = fcol_q;
  assign shared_carrier_out = shcrs_q;
  assign shared_collision_out = shcol_q;

  // Link reset: asserted at once, released on the link clock
  always_ff @(posedge fast_bus_transmit_clock or negedge nrst) begin
    if (!nrst) begin
      lrst_q <= RST_SYNC_INIT;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign lrst_n = lrst_q[1];

  always_comb begin
    lst_d = lst_q;
    word_d = word_q;
    bit_d = bit_q;
    ack_l_d = ack_l_q;
    unique case (lst_q)
      QPBMR_L_IDLE: begin
        // Slow words start on a slow clock fall so every bit is a full period
        if (req_s_q[1] != ack_l_q && (hs_data_q[WORD_FAST] || slow_clk_q)) begin
          word_d = hs_data_q;
          bit_d = '0;
          lst_d = hs_data_q[WORD_FAST] ? QPBMR_L_FAST : QPBMR_L_SLOW;
        end
      end
      QPBMR_L_FAST: begin
        lst_d = QPBMR_L_IDLE;
        ack_l_d = ~ack_l_q;
      end
      QPBMR_L_SLOW: begin
        if (slow_clk_q) begin
          bit_d = bit_q + 1'b1;
          if (bit_q == 2'(SLOW_BITS - 1)) begin
            lst_d = QPBMR_L_IDLE;
            ack_l_d = ~ack_l_q;
          end
        end
      end
      default: lst_d = QPBMR_L_IDLE;
    endcase
    // fast word is one nibble on port A
    a_valid_d = (lst_d == QPBMR_L_FAST);
    a_err_d = (lst_d == QPBMR_L_FAST) && word_d[WORD_ERR];
    a_data_d = word_d[NIB_W-1:0];
    // slow word is shifted out on port B
    b_oe_d = (lst_d == QPBMR_L_SLOW);
    b_data_d = b_oe_d && word_d[bit_d];
    // any selected channel feeds the shared inputs
    fast_tx_on = |(fast_transmit_select | shared_transmit_select);
    slow_tx_on = |(slow_transmit_select | shared_transmit_select);
    txa_hold_d = txa_hold_q;
    txa_tog_d = txa_tog_q;
    if (fast_tx_on) begin
      txa_hold_d = {port_a_tx_error, port_a_tx_data};
      txa_tog_d = ~txa_tog_q;
    end
    sb_d = sb_q;
    sb_cnt_d = sb_cnt_q;
    txb_hold_d = txb_hold_q;
    txb_tog_d = txb_tog_q;
    if (!slow_tx_on) begin
      sb_cnt_d = '0;
    end else if (!slow_clk_q) begin
      sb_d = {port_b_tx_data, sb_q[NIB_W-1:1]};
      sb_cnt_d = sb_cnt_q + 1'b1;
      if (sb_cnt_q == 2'(SLOW_BITS - 1)) begin
        txb_hold_d = {port_b_tx_data, sb_q[NIB_W-1:1]};
        txb_tog_d = ~txb_tog_q;
      end
    end
  end

  always_ff @(posedge fast_bus_transmit_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      req_s_q <= '0;
      ack_l_q <= 1'b0;
      slow_clk_q <= 1'b0;
      lst_q <= QPBMR_L_IDLE;
      word_q <= '0;
      bit_q <= '0;
      {a_valid_q, a_err_q, b_data_q, b_oe_q, txa_tog_q, txb_tog_q} <= '0;
      a_data_q <= '0;
      sb_q <= '0;
      sb_cnt_q <= '0;
      txa_hold_q <= '0;
      txb_hold_q <= '0;
    end else begin
      req_s_q <= {req_s_q[0], hs_req_q};
      ack_l_q <= ack_l_d;
      slow_clk_q <= ~slow_clk_q;
      lst_q <= lst_d;
      word_q <= word_d;
      bit_q <= bit_d;
      {a_valid_q, a_err_q, b_data_q, b_oe_q, txa_tog_q, txb_tog_q} <=
        {a_valid_d, a_err_d, b_data_d, b_oe_d, txa_tog_d, txb_tog_d};
      a_data_q <= a_data_d;
      sb_q <= sb_d;
      sb_cnt_q <= sb_cnt_d;
      txa_hold_q <= txa_hold_d;
      txb_hold_q <= txb_hold_d;
    end
  end

  // enables follow the word being driven
  assign port_a_rx_data = a_data_q;
  assign port_a_rx_valid = a_valid_q;
  assign port_a_rx_error = a_err_q;
  assign port_a_rx_oe = a_valid_q;
  assign port_b_rx_data = b_data_q;
  assign port_b_rx_oe = b_oe_q;
  assign slow_bus_receive_clock = slow_clk_q;
  assign slow_bus_transmit_clock = slow_clk_q;

  ready_to_select_a:
    assert property (@(posedge clock) disable iff (!nrst) bused |-> (ch_rx_ready & ~rx_sel) == '0)
    else $error("receive ready given to an unselected channel");
  normal_passthrough_a:
    assert property (@(posedge clock) disable iff (!nrst) !bused |=> norm_rx_valid == $past(ch_rx_valid))
    else $error("normal mode receive valid not passed through");
  separate_carrier_a:
    assert property (@(posedge clock) disable iff (!nrst)
      (bused && !smart) |=> fast_carrier_out == $past(ch_carrier & ch_fast) && shared_carrier_out == '0)
    else $error("separate submode fast carrier wrong");
  smart_carrier_a:
    assert property (@(posedge clock) disable iff (!nrst)
      (bused && smart) |=> shared_carrier_out == $past(ch_carrier) && slow_carrier_out == '0)
    else $error("smart submode carrier wrong");
  tx_event_cause_a:
    assert property (@(posedge clock) disable iff (!nrst)
      (ch_tx_valid != '0 && $past(bused)) |-> ($past(txa_ev) || $past(txb_ev)))
    else $error("bused transmit strobe without a port word");
  smart_slow_route_a:
    assert property (@(posedge clock) disable iff (!nrst)
      (bused && smart && txb_ev && !txa_ev) |=> (ch_tx_valid & $past(ch_fast)) == '0)
    else $error("serial word delivered to a fast channel");
  fast_word_once_a:
    assert property (@(posedge fast_bus_transmit_clock) disable iff (!lrst_n)
      a_valid_q |-> port_a_rx_oe && !b_oe_q && word_q[WORD_FAST] ##1 !a_valid_q)
    else $error("port A word not a single fast cycle");
  slow_word_len_a:
    assert property (@(posedge fast_bus_transmit_clock) disable iff (!lrst_n)
      $rose(b_oe_q) |-> (b_oe_q && !word_q[WORD_FAST])[*8] ##1 !b_oe_q)
    else $error("port B word not eight link cycles");
  bus_release_a:
    assert property (@(posedge fast_bus_transmit_clock) disable iff (!lrst_n)
      lst_q == QPBMR_L_IDLE |-> !port_a_rx_oe && !port_b_rx_oe)
    else $error("shared receive lines driven while idle");
  speed_steer_a:
    assert property (@(posedge fast_bus_transmit_clock) disable iff (!lrst_n)
      (lst_q == QPBMR_L_IDLE && lst_d != QPBMR_L_IDLE) |=> a_valid_q == word_q[WORD_FAST])
    else $error("word sent on the wrong port for its speed");
endmodule : qpbmr_router

// [verilog/qpbmr_stream_if.sv]
// Valid/ready word stream between router and its buffer.
// Assumes both ends on the same clock.
`timescale 1ns/1ps
interface qpbmr_stream_if
  import qpbmr_pkg::*;
#(
  parameter int WIDTH = WORD_W
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : qpbmr_stream_if
